// File: dtcp_pkg.sv
// Package of constants for the dual timer with capture and PWM
package dtcp_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_FIRST_CTRL = 4'h0;
  localparam logic [3:0] OFS_FIRST_VALUE = 4'h1;
  localparam logic [3:0] OFS_SECOND_CTRL = 4'h2;
  localparam logic [3:0] OFS_SECOND_VALUE = 4'h3;
  localparam logic [3:0] OFS_CHAN_A_DUTY = 4'h4;
  localparam logic [3:0] OFS_CHAN_B_DUTY = 4'h5;
  localparam logic [3:0] OFS_CHAN_C_DUTY = 4'h6;
  localparam logic [3:0] OFS_PWM_HIGH_BITS = 4'h7;
  localparam logic [3:0] OFS_PWM_CONTROL_THREE = 4'h8;
  localparam logic [3:0] OFS_MODE_STATUS = 4'h9;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FIRST_SEL_LSB = 0;
  localparam int FIRST_CAP_BIT = 3;
  localparam int CHAIN_BIT = 4;
  localparam int SECOND_SEL_LSB = 0;
  localparam int SECOND_CAP_BIT = 4;
  localparam int PWM_EN_BIT = 5;
  localparam int POL_LSB = 0;
  localparam int PORT_EN_LSB = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'hff;
  localparam logic [7:0] RST_DUTY = 8'h7f;
  localparam logic [7:0] RST_HIGH_BITS = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ---------------------------------------------------------------
  // Clock select codes and prescaler taps (log2 of the division)
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL0_EXT = 3'h7;
  localparam logic [3:0] SEL1_OVF = 4'hf;
  localparam int PRESC_TAPS = 15;
  localparam logic [3:0] SEL0_TAP [0:6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hb};
  localparam logic [1:0] PORT_EN_CMP16 = 2'h1;

endpackage : dtcp_pkg

// File: dtcp_prescaler.sv
// Free-running main-clock prescaler giving divide-by-2^n tick pulses
`timescale 1ns/10ps
module dtcp_prescaler (
  input wire logic clock,
  input wire logic rst_b,
  output logic [dtcp_pkg::PRESC_TAPS-1:0] div_tick
);
  import dtcp_pkg::*;

  logic [PRESC_TAPS-1:0] presc_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // Tap n pulses once every 2^n clocks
  assign div_tick[0] = 1'b1;
  genvar n;
  generate
    for (n = 1; n < PRESC_TAPS; n++) begin : g_tap
      assign div_tick[n] = &presc_r[n-1:0];
    end
  endgenerate

endmodule : dtcp_prescaler

// File: dtcp_top.sv
// Dual 8-bit timer/counter with chaining, capture, compare output and 3-channel complementary PWM
//
// Function
// - Two counters run as independent 8-bit timers or chained into one 16-bit.
// - First clock: main clock /2,/4,/8,/32,/128,/512,/2048 or external event clock.
// - Second clock: main clock /1 to /16384 or first overflow; no external clock.
// - External clock selected: pin is input, counter steps on its rising edges.
// - 8-bit mode: counter steps on its clock; match with data raises its event.
// - 16-bit mode: counts to combined data then zero; only first event raised.
// - Chaining needs chain bit and second select all ones; first is low byte.
// - Capture enable: strobe loads counter into capture register, counter restarts.
// - Capture mode still raises the match event on data equality.
// - In capture mode the shared address reads capture, otherwise the counter.
// - 16-bit capture works like 8-bit capture on the chained counter.
// - Chained, no capture, no PWM, selects 111/1111 gives 16-bit event counting.
// - Chained, no capture, no PWM, select 1111, port enables 01: 16-bit compare.
// - First pin shows compare; second shows compare or six complementary PWM pins.
// - PWM enable puts second timer in PWM mode, up to 10 bits, six outputs.
// - Period is high bits 1:0 over period low; channel A duty uses bits 7:6.
// - Duty equal period: output equals polarity; duty zero: output inverse of it.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module dtcp_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic external_event_clock,
  output logic event_pin_input,
  input wire logic capture_strobe_a,
  input wire logic capture_strobe_b,
  output logic first_match_event,
  output logic second_match_event,
  output logic first_compare_out,
  output logic second_compare_out,
  output logic [2:0] pwm_out,
  output logic [2:0] pwm_out_bar
);
  import dtcp_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] first_ctrl_r, second_ctrl_r, first_match_value_r, second_match_value_r;
  logic [7:0] chan_a_duty_r, chan_b_duty_r, chan_c_duty_r, pwm_high_bits_r;
  logic [7:0] pwm_control_three_r;
  logic [7:0] cnt0_r, cnt1_r, first_capture_value_r, second_capture_value_r;
  logic [9:0] pwm_cnt_r;
  logic [2:0] sync1_r, sync2_r, sync3_r;
  logic first_cmp_r, second_cmp_r, ev0_r, ev1_r;
  logic [2:0] pwm_r;
  logic [7:0] rdata_r;

  // ---------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------
  wire [2:0] first_clock_select = first_ctrl_r[FIRST_SEL_LSB +: 3];
  wire first_capture_enable = first_ctrl_r[FIRST_CAP_BIT];
  wire chain_enable = first_ctrl_r[CHAIN_BIT];
  wire [3:0] second_clock_select = second_ctrl_r[SECOND_SEL_LSB +: 4];
  wire second_capture_enable = second_ctrl_r[SECOND_CAP_BIT];
  wire pwm_mode_enable = second_ctrl_r[PWM_EN_BIT];
  wire [2:0] channel_polarity = pwm_control_three_r[POL_LSB +: 3];
  wire [1:0] compare_port_enables = pwm_control_three_r[PORT_EN_LSB +: 2];

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  wire [2:0] pins_in = {capture_strobe_b, capture_strobe_a, external_event_clock};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire [2:0] pin_rise = sync2_r & ~sync3_r;
  wire ext_rise = pin_rise[0];
  wire rise_a = pin_rise[1];
  wire rise_b = pin_rise[2];

  // ---------------------------------------------------------------
  // Clock selection
  // ---------------------------------------------------------------
  logic [PRESC_TAPS-1:0] div_tick;

  dtcp_prescaler u_presc (
    .clock(clock),
    .rst_b(rst_b),
    .div_tick(div_tick)
  );

  wire ext_sel = (first_clock_select == SEL0_EXT);
  assign event_pin_input = ext_sel;
  wire tick0 = ext_sel ? ext_rise : div_tick[SEL0_TAP[first_clock_select]];
  wire chained = chain_enable & (second_clock_select == SEL1_OVF);
  wire [15:0] cnt16 = {cnt1_r, cnt0_r};
  wire [15:0] cnt16_inc = cnt16 + 16'h0001;
  wire match0 = chained ? (cnt16 == {second_match_value_r, first_match_value_r})
                        : (cnt0_r == first_match_value_r);
  wire match1 = (cnt1_r == second_match_value_r);
  wire ovf0 = tick0 & match0;
  wire tick1 = (second_clock_select == SEL1_OVF) ? ovf0 : div_tick[second_clock_select];

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  wire plain16 = chained & ~first_capture_enable & ~second_capture_enable & ~pwm_mode_enable;
  wire mode_event16 = plain16 & ext_sel;
  wire mode_cmp16 = plain16 & (compare_port_enables == PORT_EN_CMP16);
  wire mode_cap16 = chained & first_capture_enable & second_capture_enable;
  wire [7:0] mode_status = {5'h00, mode_cap16, mode_cmp16, mode_event16};

  // ---------------------------------------------------------------
  // Counters and capture
  // ---------------------------------------------------------------
  wire cap_hit0 = chained ? (mode_cap16 & rise_a) : (first_capture_enable & rise_a);
  wire cap_hit1 = ~chained & ~pwm_mode_enable & second_capture_enable & rise_b;
  wire ev0 = ovf0;
  wire ev1 = ~chained & ~pwm_mode_enable & tick1 & match1;
  wire [7:0] cnt0_nxt = cap_hit0 ? RST_COUNT
                      : tick0 ? (match0 ? RST_COUNT : cnt16_inc[7:0]) : cnt0_r;
  wire [7:0] cnt1_hi_nxt = cap_hit0 ? RST_COUNT
                         : tick0 ? (match0 ? RST_COUNT : cnt16_inc[15:8]) : cnt1_r;
  wire [7:0] cnt1_lo_nxt = cap_hit1 ? RST_COUNT
                         : tick1 ? (match1 ? RST_COUNT : cnt1_r + 8'h01) : cnt1_r;
  wire [7:0] cnt1_nxt = chained ? cnt1_hi_nxt : pwm_mode_enable ? cnt1_r : cnt1_lo_nxt;
  wire second_capture_enable_load = chained ? cap_hit0 : cap_hit1;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt0_r <= RST_COUNT;
      cnt1_r <= RST_COUNT;
      first_capture_value_r <= RST_COUNT;
      second_capture_value_r <= RST_COUNT;
      ev0_r <= 1'b0;
      ev1_r <= 1'b0;
    end else begin
      cnt0_r <= cnt0_nxt;
      cnt1_r <= cnt1_nxt;
      if (cap_hit0) first_capture_value_r <= cnt0_r;
      if (second_capture_enable_load) second_capture_value_r <= cnt1_r;
      ev0_r <= ev0;
      ev1_r <= ev1;
    end
  end

  assign first_match_event = ev0_r;
  assign second_match_event = ev1_r;

  // ---------------------------------------------------------------
  // Compare outputs: toggle on each match for a 50:50 square wave
  // ---------------------------------------------------------------
  wire first_cmp_nxt = (ev0 & compare_port_enables[1] & ~chained) ? ~first_cmp_r : first_cmp_r;
  wire second_cmp_hit = mode_cmp16 ? ev0 : ev1;
  wire second_cmp_nxt = (second_cmp_hit & compare_port_enables[0]) ? ~second_cmp_r : second_cmp_r;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_cmp_r <= 1'b0;
      second_cmp_r <= 1'b0;
    end else begin
      first_cmp_r <= first_cmp_nxt;
      second_cmp_r <= second_cmp_nxt;
    end
  end

  assign first_compare_out = first_cmp_r;
  assign second_compare_out = second_cmp_r;

  // ---------------------------------------------------------------
  // PWM
  // ---------------------------------------------------------------
  wire [9:0] pwm_period = {pwm_high_bits_r[1:0], second_match_value_r};
  wire [9:0] duty [0:2];
  assign duty[0] = {pwm_high_bits_r[7:6], chan_a_duty_r};
  assign duty[1] = {pwm_high_bits_r[5:4], chan_b_duty_r};
  assign duty[2] = {pwm_high_bits_r[3:2], chan_c_duty_r};
  wire pwm_wrap = (pwm_cnt_r + 10'h001 >= pwm_period);
  wire [9:0] pwm_cnt_nxt = ~pwm_mode_enable ? 10'h000
                         : tick1 ? (pwm_wrap ? 10'h000 : pwm_cnt_r + 10'h001) : pwm_cnt_r;
  logic [2:0] pwm_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      // Counter runs 0..period-1, so duty equal period stays active throughout
      wire active = (pwm_cnt_r < duty[ch]);
      assign pwm_nxt[ch] = pwm_mode_enable & (channel_polarity[ch] ? active : ~active);
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt_r <= 10'h000;
      pwm_r <= 3'h0;
    end else begin
      pwm_cnt_r <= pwm_cnt_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm_out = pwm_r;
  assign pwm_out_bar = pwm_mode_enable ? ~pwm_r : 3'h0;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  wire wr_first_ctrl = reg_wr & (reg_addr == OFS_FIRST_CTRL);
  wire wr_first_value = reg_wr & (reg_addr == OFS_FIRST_VALUE);
  wire wr_second_ctrl = reg_wr & (reg_addr == OFS_SECOND_CTRL);
  wire wr_second_value = reg_wr & (reg_addr == OFS_SECOND_VALUE);
  wire wr_a = reg_wr & (reg_addr == OFS_CHAN_A_DUTY);
  wire wr_b = reg_wr & (reg_addr == OFS_CHAN_B_DUTY);
  wire wr_c = reg_wr & (reg_addr == OFS_CHAN_C_DUTY);
  wire wr_high = reg_wr & (reg_addr == OFS_PWM_HIGH_BITS);
  wire wr_pct = reg_wr & (reg_addr == OFS_PWM_CONTROL_THREE);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_ctrl_r <= RST_CTRL;
      second_ctrl_r <= RST_CTRL;
      first_match_value_r <= RST_MATCH;
      second_match_value_r <= RST_MATCH;
      chan_a_duty_r <= RST_DUTY;
      chan_b_duty_r <= RST_DUTY;
      chan_c_duty_r <= RST_DUTY;
      pwm_high_bits_r <= RST_HIGH_BITS;
      pwm_control_three_r <= RST_CTRL;
    end else begin
      if (wr_first_ctrl) first_ctrl_r <= reg_wdata;
      if (wr_second_ctrl) second_ctrl_r <= reg_wdata;
      if (wr_first_value) first_match_value_r <= reg_wdata;
      if (wr_second_value) second_match_value_r <= reg_wdata;
      if (wr_a) chan_a_duty_r <= reg_wdata;
      if (wr_b) chan_b_duty_r <= reg_wdata;
      if (wr_c) chan_c_duty_r <= reg_wdata;
      if (wr_high) pwm_high_bits_r <= reg_wdata;
      if (wr_pct) pwm_control_three_r <= reg_wdata;
    end
  end

  wire [7:0] first_read = first_capture_enable ? first_capture_value_r : cnt0_r;
  wire [7:0] second_read = second_capture_enable ? second_capture_value_r : cnt1_r;
  wire [7:0] rd_mux = (reg_addr == OFS_FIRST_CTRL) ? first_ctrl_r
                    : (reg_addr == OFS_FIRST_VALUE) ? first_read
                    : (reg_addr == OFS_SECOND_CTRL) ? second_ctrl_r
                    : (reg_addr == OFS_SECOND_VALUE) ? second_read
                    : (reg_addr == OFS_CHAN_A_DUTY) ? chan_a_duty_r
                    : (reg_addr == OFS_CHAN_B_DUTY) ? chan_b_duty_r
                    : (reg_addr == OFS_CHAN_C_DUTY) ? chan_c_duty_r
                    : (reg_addr == OFS_PWM_HIGH_BITS) ? pwm_high_bits_r
                    : (reg_addr == OFS_PWM_CONTROL_THREE) ? pwm_control_three_r
                    : (reg_addr == OFS_MODE_STATUS) ? mode_status
                    : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_first_match_clear: assert property (
    (~chained & tick0 & match0 & ~cap_hit0) |=> (cnt0_r == 8'h00) && first_match_event)
    else $error("first counter not cleared after match");

  chk_first_count_step: assert property (
    (~chained & tick0 & ~match0 & ~cap_hit0) |=> (cnt0_r == $past(cnt0_r) + 8'h01))
    else $error("first counter did not step on its tick");

  chk_second_match_event: assert property (
    (~chained & ~pwm_mode_enable & tick1 & match1) |=> second_match_event && ~first_match_event
      || $past(ovf0))
    else $error("second match event missing");

  chk_chain_wrap: assert property (
    (chained & tick0 & match0 & ~cap_hit0) |=> (cnt16 == 16'h0000) && first_match_event
      && ~second_match_event)
    else $error("chained counter did not wrap with single event");

  chk_chain_carry: assert property (
    (chained & tick0 & ~match0 & ~cap_hit0 & (cnt0_r == 8'hff)) |=>
      (cnt0_r == 8'h00) && (cnt1_r == $past(cnt1_r) + 8'h01))
    else $error("chained counter carry lost");

  chk_capture_load: assert property (
    (first_capture_enable & ~chained & rise_a) |=>
      (first_capture_value_r == $past(cnt0_r)) && (cnt0_r == 8'h00))
    else $error("capture did not load and restart");

  chk_read_capture: assert property (
    (reg_rd & (reg_addr == OFS_FIRST_VALUE) & first_capture_enable & ~cap_hit0) |=>
      (reg_rdata == first_capture_value_r))
    else $error("shared address did not read capture value");

  chk_ext_edge_tick: assert property (
    (ext_sel & $rose(sync2_r[0]) & ~chained & ~match0 & ~cap_hit0) |=>
      (cnt0_r == $past(cnt0_r) + 8'h01))
    else $error("external edge did not step counter");

  chk_pwm_full_duty: assert property (
    (pwm_mode_enable & (duty[2] == pwm_period) & (pwm_period != 10'h000)) |=>
      (pwm_out[2] == $past(channel_polarity[2])))
    else $error("full duty output not at polarity level");

  chk_pwm_zero_duty: assert property (
    (pwm_mode_enable & (duty[0] == 10'h000)) |=> (pwm_out[0] == ~$past(channel_polarity[0])))
    else $error("zero duty output not at inverse level");

  chk_pwm_pair_comp: assert property (
    pwm_mode_enable |-> (pwm_out_bar == ~pwm_out))
    else $error("complementary pwm pair mismatch");

  cov_chain_wrap: cover property (chained & tick0 & match0);
  cov_capture_hit: cover property (cap_hit0 ##[1:50] cap_hit0);
  cov_pwm_wrap: cover property (pwm_mode_enable & tick1 & pwm_wrap);
  cov_cmp16_toggle: cover property (mode_cmp16 & ev0);

endmodule : dtcp_top

// File: dtcp_pin_model.sv
// Model of the far-side pins: event clock and capture strobes
`timescale 1ns/10ps
module dtcp_pin_model (
  input wire logic clock,
  output logic external_event_clock,
  output logic capture_strobe_a,
  output logic capture_strobe_b
);
  initial begin
    external_event_clock = 1'b0;
    capture_strobe_a = 1'b0;
    capture_strobe_b = 1'b0;
  end

  // Levels held four clocks so the synchroniser cannot miss an edge
  task automatic event_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      external_event_clock <= 1'b1;
      repeat (4) @(posedge clock);
      external_event_clock <= 1'b0;
    end
    repeat (6) @(posedge clock);
  endtask : event_pulses

  task automatic strobe(input logic which);
    @(posedge clock);
    capture_strobe_a <= !which;
    capture_strobe_b <= which;
    repeat (4) @(posedge clock);
    capture_strobe_a <= 1'b0;
    capture_strobe_b <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : strobe
endmodule : dtcp_pin_model

// File: dtcp_top_bench.sv
// Self-checking testbench of the dual timer with capture and PWM
`timescale 1ns/10ps
module dtcp_top_bench;
  import dtcp_pkg::*;
  logic clock, rst_b, reg_wr, reg_rd, event_pin_input, first_match_event;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv, rv2, dv;
  logic second_match_event, first_compare_out, second_compare_out;
  logic [2:0] pwm_out, pwm_out_bar;
  logic external_event_clock, capture_strobe_a, capture_strobe_b;
  int n_mismatch, cmp_count;
  int c[4];
  int divs0[7] = '{2, 4, 8, 32, 128, 512, 2048};

  dtcp_top dtcp_top_i (
    .clock(clock),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .external_event_clock(external_event_clock),
    .event_pin_input(event_pin_input),
    .capture_strobe_a(capture_strobe_a),
    .capture_strobe_b(capture_strobe_b),
    .first_match_event(first_match_event),
    .second_match_event(second_match_event),
    .first_compare_out(first_compare_out),
    .second_compare_out(second_compare_out),
    .pwm_out(pwm_out),
    .pwm_out_bar(pwm_out_bar)
  );
  dtcp_pin_model dtcp_pin_model_i (
    .clock(clock),
    .external_event_clock(external_event_clock),
    .capture_strobe_a(capture_strobe_a),
    .capture_strobe_b(capture_strobe_b)
  );

  always #2.5 clock = ~clock;

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Two reads exactly n cycles apart see steps counts
  task automatic rate(input logic [3:0] a, input int n, input int steps);
    logic [7:0] x0;
    logic [7:0] x1;
    logic [7:0] d;
    rd(a, x0);
    repeat (n - 2) @(posedge clock);
    rd(a, x1);
    d = x1 - x0;
    chk(d, 16'(steps));
  endtask : rate

  task automatic watch(input int n);
    logic p0;
    logic p1;
    c = '{0, 0, 0, 0};
    p0 = first_compare_out;
    p1 = second_compare_out;
    repeat (n) begin
      @(posedge clock);
      #1;
      c[0] += (first_match_event === 1'b1);
      c[1] += (second_match_event === 1'b1);
      c[2] += (first_compare_out !== p0);
      c[3] += (second_compare_out !== p1);
      p0 = first_compare_out;
      p1 = second_compare_out;
    end
  endtask : watch

  // One full period of 260 cycles; c[3] counts broken complements
  task automatic pwm_case(input logic [7:0] hi, input logic [7:0] pol, input int e0,
                          input int e1, input int e2);
    wr(OFS_PWM_HIGH_BITS, hi);
    wr(OFS_PWM_CONTROL_THREE, pol);
    repeat (300) @(posedge clock);
    c = '{0, 0, 0, 0};
    repeat (260) begin
      @(posedge clock);
      #1;
      for (int i = 0; i < 3; i++) begin
        c[i] += (pwm_out[i] === 1'b1);
        c[3] += (pwm_out_bar[i] !== ~pwm_out[i]);
      end
    end
    chk(16'(c[0]), 16'(e0));
    chk(16'(c[1]), 16'(e1));
    chk(16'(c[2]), 16'(e2));
    chk(16'(c[3]), 16'h0000);
  endtask : pwm_case

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    #480_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk({event_pin_input, pwm_out, pwm_out_bar}, 16'h0000);
    wr(OFS_MODE_STATUS, 8'hff);
    wr(4'hc, 8'hff);
    for (int i = 0; i < 16; i++) begin
      if (i != 1 && i != 3) begin
        rd(4'(i), rv);
        chk(rv, (i >= 4 && i <= 6) ? RST_DUTY : RST_CTRL);
      end
    end
    for (int k = 0; k < 7; k++) begin
      wr(OFS_FIRST_CTRL, 8'(k));
      rate(OFS_FIRST_VALUE, divs0[k] * 4, 4);
    end
    for (int k = 0; k < 15; k++) begin
      wr(OFS_SECOND_CTRL, 8'(k));
      rate(OFS_SECOND_VALUE, 2 << k, 2);
    end
    // Match values above three; counters wrap into range during the wait
    wr(OFS_FIRST_CTRL, 8'h00);
    wr(OFS_FIRST_VALUE, 8'h04);
    wr(OFS_SECOND_CTRL, 8'h01);
    wr(OFS_SECOND_VALUE, 8'h04);
    wr(OFS_PWM_CONTROL_THREE, 8'h18);
    repeat (600) @(posedge clock);
    watch(240);
    chk(16'(c[0]), 16'd24);
    chk(16'(c[1]), 16'd24);
    chk(16'(c[2]), 16'd24);
    chk(16'(c[3]), 16'd24);
    wr(OFS_SECOND_CTRL, 8'h0f);
    wr(OFS_FIRST_CTRL, 8'h10);
    wr(OFS_PWM_CONTROL_THREE, 8'h08);
    rd(OFS_MODE_STATUS, rv);
    chk(rv, 8'h02);
    watch(4116);
    chk(16'(c[0]), 16'd2);
    chk(16'(c[1]), 16'd0);
    chk(16'(c[3]), 16'd2);
    wr(OFS_FIRST_CTRL, 8'h17);
    rd(OFS_MODE_STATUS, rv);
    chk(rv, 8'h03);
    wr(OFS_PWM_CONTROL_THREE, 8'h00);
    rd(OFS_MODE_STATUS, rv);
    chk(rv, 8'h01);
    wr(OFS_SECOND_CTRL, 8'h00);
    wr(OFS_FIRST_CTRL, 8'h07);
    wr(OFS_FIRST_VALUE, 8'hff);
    chk(event_pin_input, 1'b1);
    rd(OFS_FIRST_VALUE, rv);
    dtcp_pin_model_i.event_pulses(5);
    rd(OFS_FIRST_VALUE, rv2);
    dv = rv2 - rv;
    chk(dv, 16'd5);
    wr(OFS_FIRST_CTRL, 8'h0f);
    dtcp_pin_model_i.strobe(1'b0);
    dtcp_pin_model_i.event_pulses(6);
    dtcp_pin_model_i.strobe(1'b0);
    rd(OFS_FIRST_VALUE, rv);
    chk(rv, 8'h06);
    dtcp_pin_model_i.event_pulses(2);
    rd(OFS_FIRST_VALUE, rv);
    chk(rv, 8'h06);
    wr(OFS_FIRST_CTRL, 8'h07);
    rd(OFS_FIRST_VALUE, rv);
    chk(rv, 8'h02);
    wr(OFS_SECOND_CTRL, 8'h1f);
    wr(OFS_FIRST_CTRL, 8'h1f);
    rd(OFS_MODE_STATUS, rv);
    chk(rv, 8'h04);
    dtcp_pin_model_i.strobe(1'b0);
    dtcp_pin_model_i.event_pulses(6);
    dtcp_pin_model_i.strobe(1'b0);
    rd(OFS_FIRST_VALUE, rv);
    chk(rv, 8'h06);
    rd(OFS_SECOND_VALUE, rv);
    chk(rv, 8'h00);
    // Unchained: second counts first overflows, five event ticks each
    wr(OFS_FIRST_VALUE, 8'h04);
    wr(OFS_FIRST_CTRL, 8'h0f);
    dtcp_pin_model_i.strobe(1'b0);
    dtcp_pin_model_i.strobe(1'b1);
    dtcp_pin_model_i.event_pulses(10);
    dtcp_pin_model_i.strobe(1'b1);
    rd(OFS_SECOND_VALUE, rv);
    chk(rv, 8'h02);
    wr(OFS_FIRST_CTRL, 8'h00);
    wr(OFS_SECOND_CTRL, 8'h20);
    wr(OFS_SECOND_VALUE, 8'h04);
    wr(OFS_CHAN_A_DUTY, 8'h00);
    wr(OFS_CHAN_C_DUTY, 8'h04);
    pwm_case(8'h45, 8'h07, 256, 127, 260);
    pwm_case(8'h01, 8'h07, 0, 127, 4);
    pwm_case(8'h01, 8'h00, 260, 133, 256);
    stop_test();
  end
endmodule : dtcp_top_bench
